// [hdl/gpio_port_map.vh]
// Register indices, field positions and reset values of the port block.
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH

// Register indices; the Avalon word address equals the index.
`define IDX_PORT_F_PIN_LEVEL    7'h20
`define IDX_PORT_E_PIN_LEVEL    7'h21
`define IDX_PORT_E_DIRECTION    7'h22
`define IDX_PORT_E_OUTPUT_LATCH 7'h23
`define IDX_PORT_D_PIN_LEVEL    7'h30
`define IDX_PORT_D_DIRECTION    7'h31
`define IDX_PORT_D_OUTPUT_LATCH 7'h32
`define IDX_SPECIAL_FUNCTION    7'h40
`define IDX_PORT_F_DIRECTION    7'h61
`define IDX_PORT_F_OUTPUT_LATCH 7'h62
`define IDX_PORT_G_PIN_LEVEL    7'h63
`define IDX_PORT_G_DIRECTION    7'h64
`define IDX_PORT_G_OUTPUT_LATCH 7'h65

// Reset values of the writable registers.
`define RST_PORT_REG            8'h00
`define RST_SPECIAL_FUNCTION    8'h00

// Writable bit masks: port G keeps bits 4..0, the shared register 7, 3..0.
`define MASK_PORT_G             8'h1f
`define MASK_SPECIAL_FUNCTION   8'h8f

// Position of the global pull-up disable bit.
`define POS_PULLUP_DISABLE      2

// Answer of an unmapped or removed register.
`define READ_UNMAPPED           8'h00

`endif

// [hdl/gpio_pin_sync.v]
// Two-flop synchroniser for a group of asynchronous pin levels.
module gpio_pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] level_o
);

  // First stage; only the second stage ever reads it.
  reg [WIDTH-1:0] meta_q;
  // Second stage; safe for the rest of the block.
  reg [WIDTH-1:0] level_q;

  // Both stages clear on reset so that simulation starts defined, even
  // though software must treat the pin level as undefined until sampled.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q  <= {WIDTH{1'b0}};
      level_q <= {WIDTH{1'b0}};
    end else begin
      meta_q  <= pin_i;
      level_q <= meta_q;
    end
  end

  assign level_o = level_q;

endmodule // gpio_pin_sync

// [hdl/gpio_pad_ctrl.v]
// Per-pin pad drive, output enable and pull-up control for one port.
module gpio_pad_ctrl #(
  parameter WIDTH = 8
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] direction_i,
  input  wire [WIDTH-1:0] latch_i,
  input  wire             pullup_disable_i,
  input  wire             alt_en_i,
  input  wire [WIDTH-1:0] alt_value_i,
  input  wire [WIDTH-1:0] alt_drive_i,
  output wire [WIDTH-1:0] pad_out_o,
  output wire [WIDTH-1:0] pad_oe_n_o,
  output wire [WIDTH-1:0] pad_pullup_o
);

  reg [WIDTH-1:0] out_q;     // Level driven onto the pad.
  reg [WIDTH-1:0] oe_n_q;    // Low while the pad is driven.
  reg [WIDTH-1:0] pullup_q;  // High while the pull-up is on.

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      // Each pin is registered so the pads see no decode glitches.
      always @(posedge clk_i) begin
        if (!rst_n_i) begin
          out_q[i]    <= 1'b0;
          oe_n_q[i]   <= 1'b1;
          pullup_q[i] <= 1'b0;
        end else if (alt_en_i) begin
          // Alternate function owns the pin; the pull-up stays off.
          out_q[i]    <= alt_value_i[i];
          oe_n_q[i]   <= ~alt_drive_i[i];
          pullup_q[i] <= 1'b0;
        end else begin
          out_q[i]    <= latch_i[i];
          oe_n_q[i]   <= ~direction_i[i];
          // Input with latch one gets the pull-up unless disabled.
          pullup_q[i] <= ~direction_i[i] & latch_i[i] & ~pullup_disable_i;
        end
      end
    end
  endgenerate

  assign pad_out_o    = out_q;
  assign pad_oe_n_o   = oe_n_q;
  assign pad_pullup_o = pullup_q;

endmodule // gpio_pad_ctrl

// [hdl/gpio_ports_d_to_g.v]
// Register file and pad control of general-purpose ports D, E, F and G.
// Every bus access takes two cycles: waitrequest is high in the cycle the
// request appears and low in the next, at whose edge the write lands and
// the read data stand.
//
// The Avalon-MM register port was decided locally.

`include "gpio_port_map.vh"

module gpio_ports_d_to_g (
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Avalon-MM slave, word addressed.
  input  wire [6:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // Legacy compatibility fuse level, asynchronous.
  input  wire        legacy_mode_i,
  // Port G alternate functions used in legacy mode.
  input  wire [4:0]  port_g_alt_value_i,
  input  wire [4:0]  port_g_alt_drive_i,
  // Other bits of the shared register for neighbouring blocks.
  output wire [7:0]  special_function_o,
  // Pins of port D.
  input  wire [7:0]  port_d_pin_i,
  output wire [7:0]  port_d_out_o,
  output wire [7:0]  port_d_oe_n_o,
  output wire [7:0]  port_d_pullup_o,
  // Pins of port E.
  input  wire [7:0]  port_e_pin_i,
  output wire [7:0]  port_e_out_o,
  output wire [7:0]  port_e_oe_n_o,
  output wire [7:0]  port_e_pullup_o,
  // Pins of port F.
  input  wire [7:0]  port_f_pin_i,
  output wire [7:0]  port_f_out_o,
  output wire [7:0]  port_f_oe_n_o,
  output wire [7:0]  port_f_pullup_o,
  // Pins of port G.
  input  wire [4:0]  port_g_pin_i,
  output wire [4:0]  port_g_out_o,
  output wire [4:0]  port_g_oe_n_o,
  output wire [4:0]  port_g_pullup_o
);

  // Software-visible registers.
  reg  [7:0]  port_d_output_latch_q;
  reg  [7:0]  port_d_direction_q;
  reg  [7:0]  port_e_output_latch_q;
  reg  [7:0]  port_e_direction_q;
  reg  [7:0]  port_f_output_latch_q;
  reg  [7:0]  port_f_direction_q;
  reg  [7:0]  port_g_output_latch_q;
  reg  [7:0]  port_g_direction_q;
  reg  [7:0]  special_function_control_q;

  // Bus handshake state.
  reg         waitreq_q;     // High except in the answer cycle.
  reg  [31:0] readdata_q;    // Read data, stands in the answer cycle.
  reg  [7:0]  rd_d;          // Decoded read value.

  // Legacy fuse synchroniser; only legacy_q is read by logic.
  reg         legacy_meta_q;
  reg         legacy_q;

  // Synchronised pin levels.
  wire [7:0]  port_d_pin_level;
  wire [7:0]  port_e_pin_level;
  wire [7:0]  port_f_pin_level;
  wire [4:0]  port_g_pin_level;

  wire        req;           // A request is on the bus.
  wire        accept;        // The edge where the request completes.
  wire        wr_en;         // Write takes effect at this edge.
  wire [7:0]  wdata;         // Only the low byte lane carries data.
  wire        global_pullup_disable;           // Global pull-up disable.

  // Effective port F settings once legacy mode is applied.
  wire [7:0]  port_f_dir_eff;
  wire [7:0]  port_f_latch_eff;

  assign req    = avs_read_i | avs_write_i;
  assign accept = req & ~waitreq_q;
  // A write without lane 0 enabled carries nothing for these registers.
  assign wr_en  = avs_write_i & ~waitreq_q & avs_byteenable_i[0];
  assign wdata  = avs_writedata_i[7:0];
  assign global_pullup_disable    = special_function_control_q[`POS_PULLUP_DISABLE];

  // The fuse may change at any time relative to clk_i, so it passes two
  // flip-flops before steering the decode and pads.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      legacy_meta_q <= 1'b0;
      legacy_q      <= 1'b0;
    end else begin
      legacy_meta_q <= legacy_mode_i;
      legacy_q      <= legacy_meta_q;
    end
  end

  // Handshake: drop waitrequest for one cycle after a request is seen.
  // The extra cycle costs throughput but keeps every output registered.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      waitreq_q <= 1'b1;
    end else if (req && waitreq_q) begin
      waitreq_q <= 1'b0;
    end else begin
      waitreq_q <= 1'b1;
    end
  end

  // Read decode; removed and unmapped registers answer zero.
  always @* begin
    rd_d = `READ_UNMAPPED;
    case (avs_address_i)
      `IDX_PORT_D_OUTPUT_LATCH: rd_d = port_d_output_latch_q;
      `IDX_PORT_D_DIRECTION:    rd_d = port_d_direction_q;
      `IDX_PORT_D_PIN_LEVEL:    rd_d = port_d_pin_level;
      `IDX_PORT_E_OUTPUT_LATCH: rd_d = port_e_output_latch_q;
      `IDX_PORT_E_DIRECTION:    rd_d = port_e_direction_q;
      `IDX_PORT_E_PIN_LEVEL:    rd_d = port_e_pin_level;
      `IDX_PORT_F_OUTPUT_LATCH: begin
        // Hidden in legacy mode.
        rd_d = legacy_q ? `READ_UNMAPPED : port_f_output_latch_q;
      end
      `IDX_PORT_F_DIRECTION: begin
        rd_d = legacy_q ? `READ_UNMAPPED : port_f_direction_q;
      end
      `IDX_PORT_F_PIN_LEVEL: begin
        // Port F stays readable as digital inputs in legacy mode.
        rd_d = port_f_pin_level;
      end
      `IDX_PORT_G_OUTPUT_LATCH: begin
        // Reserved high bits hold zero, so they read zero.
        rd_d = legacy_q ? `READ_UNMAPPED : port_g_output_latch_q;
      end
      `IDX_PORT_G_DIRECTION: begin
        rd_d = legacy_q ? `READ_UNMAPPED : port_g_direction_q;
      end
      `IDX_PORT_G_PIN_LEVEL: begin
        // Bits 7..5 read zero.
        rd_d = legacy_q ? `READ_UNMAPPED : {3'h0, port_g_pin_level};
      end
      `IDX_SPECIAL_FUNCTION:    rd_d = special_function_control_q;
      default:                  rd_d = `READ_UNMAPPED;
    endcase
  end

  // Read data are captured as waitrequest falls and held until the next
  // read, so they stand at the edge where the master samples them.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      readdata_q <= 32'h00000000;
    end else if (avs_read_i && waitreq_q) begin
      readdata_q <= {24'h000000, rd_d};
    end
  end

  // Port D and E registers: plain read/write bytes.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      port_d_output_latch_q <= `RST_PORT_REG;
      port_d_direction_q    <= `RST_PORT_REG;
      port_e_output_latch_q <= `RST_PORT_REG;
      port_e_direction_q    <= `RST_PORT_REG;
    end else if (wr_en) begin
      case (avs_address_i)
        `IDX_PORT_D_OUTPUT_LATCH: begin
          port_d_output_latch_q <= wdata;
        end
        `IDX_PORT_D_DIRECTION: begin
          port_d_direction_q <= wdata;
        end
        `IDX_PORT_E_OUTPUT_LATCH: begin
          port_e_output_latch_q <= wdata;
        end
        `IDX_PORT_E_DIRECTION: begin
          port_e_direction_q <= wdata;
        end
        default: ;  // Writes elsewhere, as to pin levels, are dropped.
      endcase
    end
  end

  // Port F and G registers; in legacy mode they do not exist, so writes
  // are dropped and the stored values stay as they were.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      port_f_output_latch_q <= `RST_PORT_REG;
      port_f_direction_q    <= `RST_PORT_REG;
      port_g_output_latch_q <= `RST_PORT_REG;
      port_g_direction_q    <= `RST_PORT_REG;
    end else if (wr_en && !legacy_q) begin
      case (avs_address_i)
        `IDX_PORT_F_OUTPUT_LATCH: begin
          port_f_output_latch_q <= wdata;
        end
        `IDX_PORT_F_DIRECTION: begin
          port_f_direction_q <= wdata;
        end
        `IDX_PORT_G_OUTPUT_LATCH: begin
          // Reserved bits ignore the write.
          port_g_output_latch_q <= wdata & `MASK_PORT_G;
        end
        `IDX_PORT_G_DIRECTION: begin
          port_g_direction_q <= wdata & `MASK_PORT_G;
        end
        default: ;  // Nothing else lives in this group.
      endcase
    end
  end

  // Shared special-function register; bits 6..4 stay zero.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      special_function_control_q <= `RST_SPECIAL_FUNCTION;
    end else if (wr_en && avs_address_i == `IDX_SPECIAL_FUNCTION) begin
      special_function_control_q <= wdata & `MASK_SPECIAL_FUNCTION;
    end
  end

  // In legacy mode port F acts as input only with no pull-up.
  assign port_f_dir_eff   = legacy_q ? 8'h00 : port_f_direction_q;
  assign port_f_latch_eff = legacy_q ? 8'h00 : port_f_output_latch_q;

  // Pin samplers; the level registers read back these second stages.
  gpio_pin_sync #(.WIDTH(8)) u_sync_d (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (port_d_pin_i),
    .level_o (port_d_pin_level)
  );

  gpio_pin_sync #(.WIDTH(8)) u_sync_e (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (port_e_pin_i),
    .level_o (port_e_pin_level)
  );

  gpio_pin_sync #(.WIDTH(8)) u_sync_f (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (port_f_pin_i),
    .level_o (port_f_pin_level)
  );

  gpio_pin_sync #(.WIDTH(5)) u_sync_g (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (port_g_pin_i),
    .level_o (port_g_pin_level)
  );

  // Pad control; pull-up gating lives inside each instance.
  gpio_pad_ctrl #(.WIDTH(8)) u_pad_d (
    .clk_i            (clk_i),
    .rst_n_i          (rst_n_i),
    .direction_i      (port_d_direction_q),
    .latch_i          (port_d_output_latch_q),
    .pullup_disable_i (global_pullup_disable),
    .alt_en_i         (1'b0),
    .alt_value_i      (8'h00),
    .alt_drive_i      (8'h00),
    .pad_out_o        (port_d_out_o),
    .pad_oe_n_o       (port_d_oe_n_o),
    .pad_pullup_o     (port_d_pullup_o)
  );

  gpio_pad_ctrl #(.WIDTH(8)) u_pad_e (
    .clk_i            (clk_i),
    .rst_n_i          (rst_n_i),
    .direction_i      (port_e_direction_q),
    .latch_i          (port_e_output_latch_q),
    .pullup_disable_i (global_pullup_disable),
    .alt_en_i         (1'b0),
    .alt_value_i      (8'h00),
    .alt_drive_i      (8'h00),
    .pad_out_o        (port_e_out_o),
    .pad_oe_n_o       (port_e_oe_n_o),
    .pad_pullup_o     (port_e_pullup_o)
  );

  gpio_pad_ctrl #(.WIDTH(8)) u_pad_f (
    .clk_i            (clk_i),
    .rst_n_i          (rst_n_i),
    .direction_i      (port_f_dir_eff),
    .latch_i          (port_f_latch_eff),
    .pullup_disable_i (global_pullup_disable),
    .alt_en_i         (1'b0),
    .alt_value_i      (8'h00),
    .alt_drive_i      (8'h00),
    .pad_out_o        (port_f_out_o),
    .pad_oe_n_o       (port_f_oe_n_o),
    .pad_pullup_o     (port_f_pullup_o)
  );

  // In legacy mode port G hands its pins to the alternate functions.
  gpio_pad_ctrl #(.WIDTH(5)) u_pad_g (
    .clk_i            (clk_i),
    .rst_n_i          (rst_n_i),
    .direction_i      (port_g_direction_q[4:0]),
    .latch_i          (port_g_output_latch_q[4:0]),
    .pullup_disable_i (global_pullup_disable),
    .alt_en_i         (legacy_q),
    .alt_value_i      (port_g_alt_value_i),
    .alt_drive_i      (port_g_alt_drive_i),
    .pad_out_o        (port_g_out_o),
    .pad_oe_n_o       (port_g_oe_n_o),
    .pad_pullup_o     (port_g_pullup_o)
  );

  assign avs_readdata_o     = readdata_q;
  assign avs_waitrequest_o  = waitreq_q;
  assign special_function_o = special_function_control_q;

endmodule // gpio_ports_d_to_g

// [tb/gpio_pin_model.sv]
// Board-side model of one port's pins: pad drive, pull-up and board level.
module gpio_pin_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] out_i,    // Pad output value.
  input  wire logic [7:0] oe_n_i,   // Low while the pad drives the pin.
  input  wire logic [7:0] pullup_i, // High while the pull-up is on.
  input  wire logic [7:0] ext_i,    // Level that the board forces.
  input  wire logic [7:0] ext_en_i, // High where the board forces a level.
  output wire logic [7:0] pin_o     // Resolved level on the wire.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q = 8'h00;  // Level seen one cycle ago.

  // A floating pin flips every cycle, so a read of it never passes by luck.
  always @(posedge clk_i) begin
    last_q <= pin_o;
  end

  // The pad wins over the board; the pull-up lifts only an undriven pin.
  assign pin_o = (~oe_n_i & out_i) | (oe_n_i & ext_en_i & ext_i) |
                 (oe_n_i & ~ext_en_i & (pullup_i | ~last_q));
endmodule // gpio_pin_model

// [tb/gpio_ports_d_to_g_chk.sv]
// Concurrent checks on the bus and pad outputs of the port block.
module gpio_ports_d_to_g_chk (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [6:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        legacy_mode_i,
  input wire logic [4:0]  port_g_alt_value_i,
  input wire logic [4:0]  port_g_alt_drive_i,
  input wire logic [7:0]  special_function_o,
  input wire logic [7:0]  port_d_pin_i,
  input wire logic [7:0]  port_d_oe_n_o,
  input wire logic [7:0]  port_d_pullup_o,
  input wire logic [7:0]  port_e_oe_n_o,
  input wire logic [7:0]  port_e_pullup_o,
  input wire logic [7:0]  port_f_oe_n_o,
  input wire logic [7:0]  port_f_pullup_o,
  input wire logic [4:0]  port_g_out_o,
  input wire logic [4:0]  port_g_oe_n_o,
  input wire logic [4:0]  port_g_pullup_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // A read that completes at the given index.
  sequence rd_done(logic [6:0] idx);
    avs_read_i && !avs_waitrequest_o && avs_address_i == idx;
  endsequence
  // Legacy fuse held long enough to pass the synchroniser and pad stage.
  sequence legacy_held;
    legacy_mode_i [*6];
  endsequence

  a_wait_one_cycle: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("waitrequest not low for exactly one cycle");
  a_upper_zero: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("read data above the low byte not zero");
  a_g_reserved: assert property ((rd_done(7'h63) or rd_done(7'h64) or
    rd_done(7'h65)) |-> avs_readdata_o[7:5] == 3'h0)
    else $error("port G bits 7 to 5 not zero");
  a_sfc_reserved: assert property (rd_done(7'h40) |->
    avs_readdata_o[6:4] == 3'h0) else $error("shared bits 6 to 4 not zero");
  a_no_pull_drive: assert property ((port_d_pullup_o & ~port_d_oe_n_o) ==
    8'h0 && (port_e_pullup_o & ~port_e_oe_n_o) == 8'h0)
    else $error("pull-up on a driven pin");
  a_pud_all_off: assert property (special_function_o[2] &&
    $past(special_function_o[2]) |-> {port_d_pullup_o, port_e_pullup_o,
    port_f_pullup_o, port_g_pullup_o} == 29'h0)
    else $error("pull-up on while disabled");
  a_dir_to_pad: assert property (avs_write_i && !avs_waitrequest_o &&
    avs_byteenable_i[0] && avs_address_i == 7'h31 |->
    ##2 port_d_oe_n_o == ~$past(avs_writedata_i[7:0], 2))
    else $error("port D drive does not follow direction");
  a_pin_to_level: assert property ($stable(port_d_pin_i) [*5] ##0
    rd_done(7'h30) |-> avs_readdata_o[7:0] == port_d_pin_i)
    else $error("port D level read differs from pins");
  a_legacy_f_off: assert property (legacy_held |-> port_f_oe_n_o ==
    8'hff && port_f_pullup_o == 8'h0) else $error("port F driven in legacy");
  a_legacy_g_alt: assert property (legacy_held ##0
    $stable(port_g_alt_value_i) && $stable(port_g_alt_drive_i) |->
    port_g_out_o == port_g_alt_value_i && port_g_pullup_o == 5'h0 &&
    port_g_oe_n_o == ~port_g_alt_drive_i) else $error("port G not alternate");
  a_legacy_hidden: assert property (legacy_held ##0 avs_read_i &&
    !avs_waitrequest_o && avs_address_i >= 7'h61 && avs_address_i <= 7'h65
    |-> avs_readdata_o[7:0] == 8'h0) else $error("removed register not zero");
endmodule // gpio_ports_d_to_g_chk

bind gpio_ports_d_to_g gpio_ports_d_to_g_chk gpio_ports_d_to_g_chk_inst (.*);

// [tb/gpio_ports_d_to_g_test.sv]
// Self-checking bench for the port D to G register block.
module gpio_ports_d_to_g_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [6:0]  avs_address_i = 7'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        legacy_mode_i = 1'b0;
  logic [4:0]  port_g_alt_value_i = 5'h16;  // Alternate value in legacy.
  logic [4:0]  port_g_alt_drive_i = 5'h0b;  // Alternate drive in legacy.
  logic [7:0]  special_function_o;
  logic [7:0]  port_d_out_o, port_d_oe_n_o, port_d_pullup_o;
  logic [7:0]  port_e_out_o, port_e_oe_n_o, port_e_pullup_o;
  logic [7:0]  port_f_out_o, port_f_oe_n_o, port_f_pullup_o;
  logic [4:0]  port_g_out_o, port_g_oe_n_o, port_g_pullup_o;
  wire  [7:0]  port_d_pin_i, port_e_pin_i, port_f_pin_i;
  wire  [4:0]  port_g_pin_i;
  wire  [2:0]  pin_g_spare;                 // Unbonded upper port G bits.
  logic [31:0] ext = 32'h0;                 // Board levels, G F E D.
  logic [31:0] board_en = 32'hffffffff;     // Board drives where high.
  int          err_total = 0;
  int          cmp_count = 0;
  // Writable registers and the bits that hold a value.
  logic [6:0]  ra [9] = '{7'h23, 7'h22, 7'h32, 7'h31, 7'h62, 7'h61,
                          7'h65, 7'h64, 7'h40};
  logic [7:0]  rm [9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                          8'h1f, 8'h1f, 8'h8f};

  gpio_ports_d_to_g gpio_ports_d_to_g_inst (.*);
  gpio_pin_model gpio_pin_model_inst [3:0] (.clk_i(clk_i), .ext_i(ext),
    .out_i({3'h0, port_g_out_o, port_f_out_o, port_e_out_o, port_d_out_o}),
    .oe_n_i({3'h7, port_g_oe_n_o, port_f_oe_n_o, port_e_oe_n_o,
             port_d_oe_n_o}), .ext_en_i(board_en),
    .pullup_i({3'h0, port_g_pullup_o, port_f_pullup_o, port_e_pullup_o,
               port_d_pullup_o}),
    .pin_o({pin_g_spare, port_g_pin_i, port_f_pin_i, port_e_pin_i,
            port_d_pin_i}));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // Compares one byte and counts the outcome.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write; the request stands until waitrequest is sampled low.
  task automatic wr(input logic [6:0] a, input logic [7:0] d,
                    input logic be = 1'b1);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= {3'h7, be};
    avs_write_i <= 1'b1;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Bus read; data are taken at the edge that sees waitrequest low.
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    chk(avs_readdata_o[7:0], exp);
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    end_sim();
  end

  // Main sequence.
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    foreach (ra[i]) rd(ra[i], 8'h00);
    // Two patterns catch both stuck and reserved bits.
    foreach (ra[i]) wr(ra[i], 8'hff);
    foreach (ra[i]) rd(ra[i], rm[i]);
    foreach (ra[i]) wr(ra[i], 8'h5a);
    foreach (ra[i]) rd(ra[i], rm[i] & 8'h5a);
    wr(ra[0], 8'h00, 1'b0);
    rd(ra[0], 8'h5a);
    wr(7'h7f, 8'hff);
    rd(7'h7f, 8'h00);
    // All ports as inputs; the board sets the levels.
    foreach (ra[i]) wr(ra[i], 8'h00);
    ext <= 32'hf3c69e3a;
    wr(7'h30, 8'hff);
    rd(7'h30, 8'h3a);
    rd(7'h21, 8'h9e);
    rd(7'h20, 8'hc6);
    rd(7'h63, 8'h13);
    // Port D drives; the pins loop back into its level register. The
    // pins settle for a few cycles so the checker's level check can fire.
    wr(7'h31, 8'hff);
    wr(7'h32, 8'ha5);
    repeat (4) @(posedge clk_i);
    chk(port_d_oe_n_o, 8'h00);
    chk(port_d_out_o, 8'ha5);
    rd(7'h30, 8'ha5);
    // Pull-ups on floating inputs, then the global disable.
    board_en <= 32'h0;
    wr(7'h23, 8'h0f);
    wr(7'h22, 8'h03);
    wr(7'h65, 8'h1f);
    @(posedge clk_i);
    chk(port_e_out_o, 8'h0f);
    chk(port_e_pullup_o, 8'h0c);
    chk({3'h0, port_g_pullup_o}, 8'h1f);
    wr(7'h40, 8'h04);
    @(posedge clk_i);
    chk(special_function_o, 8'h04);
    chk(port_e_pullup_o, 8'h00);
    chk({3'h0, port_g_pullup_o}, 8'h00);
    wr(7'h40, 8'h00);
    @(posedge clk_i);
    chk(port_e_pullup_o, 8'h0c);
    // Legacy mode hides F and G, except the F pin level, but keeps what they hold.
    board_en <= 32'hffffffff;
    wr(7'h62, 8'h3c);
    wr(7'h61, 8'hf0);
    wr(7'h65, 8'h0a);
    wr(7'h64, 8'h05);
    legacy_mode_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    wr(7'h62, 8'hff);
    for (int a = 8'h61; a <= 8'h65; a++) rd(a[6:0], 8'h00);
    rd(7'h20, 8'hc6);
    chk(port_f_oe_n_o, 8'hff);
    chk(port_f_out_o, 8'h00);
    chk({3'h0, port_g_out_o}, 8'h16);
    chk({3'h0, port_g_oe_n_o}, 8'h14);
    legacy_mode_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(7'h62, 8'h3c);
    rd(7'h61, 8'hf0);
    rd(7'h65, 8'h0a);
    rd(7'h64, 8'h05);
    // A second reset in mid-run must clear what the tests left behind.
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk(port_d_oe_n_o, 8'hff);
    foreach (ra[i]) rd(ra[i], 8'h00);
    end_sim();
  end
endmodule // gpio_ports_d_to_g_test
